// ===== rtl/usfi_global_irq.sv
// usfi_global_irq: global interrupt flags, enables and interrupt line
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps

// Function
// - host mode: tx fifo empty flag at half or full empty, per threshold bit
// - rx fifo non-empty flag set while at least one entry is held
// - host mode: frame start flag set before sending frame start or keep-alive
// - device mode: frame start flag set on received token; frame number readable
// - frame start flag clears on writing one; writing zero keeps it
// - otg summary flag follows the or of all otg flags
// - mode fault flag set on wrong-role register access
// - an access causing mode fault has no effect
// - bit zero reads current role: zero device, one host
// - enable register sits at 0x18 and resets to zero
// - disabled sources raise no interrupt but still set their flag
// - bit 31 gates wakeup, bit 30 gates session, both roles
// - bit 29 gates disconnect, device mode only
// - bit 28 gates id pin change in both roles
// - host only: bit 26 periodic tx empty, 25 channels, 24 port
// - bit 21 gates periodic incomplete in host, iso out incomplete in device
// - device only: bit 20 iso in incomplete, 19 out endpoints, 18 in endpoints
// - device only: bit 15 end of frame, 14 iso dropped, 13 enumeration done
// - bits 5 to 1 gate tx empty, rx non-empty, frame start, otg, mode fault
// - device only: bits 12, 11, 10, 7, 6 gate reset, suspend, early suspend, naks
module usfi_global_irq #(
	parameter int FRAME_W = usfi_pkg::FRAME_W_DEF,
	parameter int RX_CNT_W = usfi_pkg::RX_CNT_W_DEF,
	parameter int OTG_W = usfi_pkg::OTG_W_DEF
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic [usfi_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic HOST_MODE,
	input wire logic NPTX_HALF_EMPTY,
	input wire logic NPTX_EMPTY,
	input wire logic [RX_CNT_W-1:0] RX_ENTRY_COUNT,
	input wire logic SOF_EVENT,
	input wire logic [OTG_W-1:0] OTG_FLAGS,
	input wire logic [31:6] UPPER_FLAGS,
	input wire logic [FRAME_W-1:0] FRAME_NUMBER,
	output logic IRQ
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// expand byte enables into a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return m;
	endfunction

	// class of the register at an address
	function automatic usfi_pkg::usfi_cls_t addr_class(input logic [11:0] a);
		usfi_pkg::usfi_cls_t c;
		case (a)
			usfi_pkg::OFS_BUS_CFG: c = usfi_pkg::USFI_CLS_BOTH;
			usfi_pkg::OFS_FLAGS: c = usfi_pkg::USFI_CLS_BOTH;
			usfi_pkg::OFS_ENABLE: c = usfi_pkg::USFI_CLS_BOTH;
			usfi_pkg::OFS_HOST_FRAME: c = usfi_pkg::USFI_CLS_HOST;
			usfi_pkg::OFS_DEV_STATUS: c = usfi_pkg::USFI_CLS_DEV;
			default: c = usfi_pkg::USFI_CLS_NONE;
		endcase
		return c;
	endfunction

	// bits that belong to the role not now active
	function automatic logic [31:0] off_role_mask(input logic host);
		logic [31:0] m;
		m = host ? usfi_pkg::DEV_ONLY_MASK : usfi_pkg::HOST_ONLY_MASK;
		return m;
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	usfi_pkg::usfi_avs_req_t req;
	usfi_pkg::usfi_core_evt_t evt;
	usfi_pkg::usfi_cls_t cls;
	logic req_valid;
	logic sample;
	logic commit;
	logic wrong_role;
	logic [31:0] wmask;
	logic [31:0] keep_mask;
	logic [31:0] en_ff;
	logic [31:0] nxt_en;
	logic [31:0] cfg_ff;
	logic [31:0] nxt_cfg;
	logic sof_ff;
	logic nxt_sof;
	logic mf_ff;
	logic nxt_mf;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic irq_ff;
	logic nxt_irq;
	logic nptx_flag;
	logic otg_flag;
	logic [31:0] flags;
	logic [31:0] frame_word;
	logic [31:0] shared_src;
	logic [31:0] host_src;
	logic [31:0] dev_src;

	// ------------------------------------------------------------
	// input grouping
	// ------------------------------------------------------------
	assign req.read = AVS_READ;
	assign req.write = AVS_WRITE;
	assign req.address = AVS_ADDRESS;
	assign req.byteenable = AVS_BYTEENABLE;
	assign req.writedata = AVS_WRITEDATA;
	assign evt.nptx_half_empty = NPTX_HALF_EMPTY;
	assign evt.nptx_empty = NPTX_EMPTY;
	assign evt.rx_nonempty = (RX_ENTRY_COUNT != '0);
	assign evt.sof_event = SOF_EVENT;
	assign req_valid = req.read | req.write;

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	// one wait state; the write lands on the edge the master sees ready
	usfi_avs_handshake u_hs (
		.clk(CORE_CLK),
		.rst(RESET),
		.req_valid(req_valid),
		.sample(sample),
		.commit(commit),
		.waitrequest(AVS_WAITREQUEST)
	);

	// ------------------------------------------------------------
	// address decode and role check
	// ------------------------------------------------------------
	// wrong-role access detect
	always_comb begin
		cls = addr_class(req.address);
		wrong_role = 1'b0;
		if (cls == usfi_pkg::USFI_CLS_HOST && !HOST_MODE) begin
			wrong_role = 1'b1;
		end
		if (cls == usfi_pkg::USFI_CLS_DEV && HOST_MODE) begin
			wrong_role = 1'b1;
		end
	end

	// bits a write may touch: enabled byte lanes only
	assign wmask = be_mask(req.byteenable);

	assign keep_mask = off_role_mask(HOST_MODE);

	// ------------------------------------------------------------
	// live status flags
	// ------------------------------------------------------------
	// level flags follow their sources, so no clear is needed
	always_comb begin
		// threshold picks half or full empty
		if (cfg_ff[usfi_pkg::BIT_TX_THRESHOLD]) begin
			nptx_flag = HOST_MODE & evt.nptx_empty;
		end else begin
			nptx_flag = HOST_MODE & (evt.nptx_half_empty | evt.nptx_empty);
		end
		otg_flag = |OTG_FLAGS;
	end

	// assemble the flag word seen by software and the interrupt
	always_comb begin
		flags = '0;
		// upper flags come from elsewhere; mask off the idle role
		flags[31:6] = UPPER_FLAGS & ~keep_mask[31:6];
		flags[usfi_pkg::BIT_NPTX_EMPTY] = nptx_flag;
		flags[usfi_pkg::BIT_RX_NONEMPTY] = evt.rx_nonempty;
		flags[usfi_pkg::BIT_SOF] = sof_ff;
		flags[usfi_pkg::BIT_OTG] = otg_flag;
		flags[usfi_pkg::BIT_MODE_FAULT] = mf_ff;
		flags[usfi_pkg::BIT_ROLE] = HOST_MODE;
	end

	// frame number as shown in the role status registers
	always_comb begin
		frame_word = '0;
		frame_word[FRAME_W-1:0] = FRAME_NUMBER;
	end

	// ------------------------------------------------------------
	// sticky flags
	// ------------------------------------------------------------
	// set wins over a same-cycle clear so no frame start is lost
	always_comb begin
		nxt_sof = sof_ff;
		nxt_mf = mf_ff;
		if (commit && req.write && cls == usfi_pkg::USFI_CLS_BOTH &&
			req.address == usfi_pkg::OFS_FLAGS) begin
			if (wmask[usfi_pkg::BIT_SOF] && req.writedata[usfi_pkg::BIT_SOF]) begin
				nxt_sof = 1'b0;
			end
			if (wmask[usfi_pkg::BIT_MODE_FAULT] && req.writedata[usfi_pkg::BIT_MODE_FAULT]) begin
				nxt_mf = 1'b0;
			end
		end
		// frame start in either role: host frame about to go out or device token received
		if (evt.sof_event) begin
			nxt_sof = 1'b1;
		end
		if (commit && wrong_role) begin
			nxt_mf = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// enable and configuration registers
	// ------------------------------------------------------------
	always_comb begin
		nxt_en = en_ff;
		nxt_cfg = cfg_ff;
		if (commit && req.write && !wrong_role) begin
			if (req.address == usfi_pkg::OFS_ENABLE) begin
				// other-role enables stay as they were
				nxt_en = (en_ff & ~(wmask & usfi_pkg::EN_WRITABLE_MASK & ~keep_mask)) |
					(req.writedata & wmask & usfi_pkg::EN_WRITABLE_MASK & ~keep_mask);
			end
			if (req.address == usfi_pkg::OFS_BUS_CFG) begin
				nxt_cfg = (cfg_ff & ~(wmask & usfi_pkg::CFG_WRITABLE_MASK)) |
					(req.writedata & wmask & usfi_pkg::CFG_WRITABLE_MASK);
			end
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// captured one edge ahead so data stands when waitrequest drops
	always_comb begin
		nxt_rdata = rdata_ff;
		if (sample) begin
			nxt_rdata = usfi_pkg::READ_ZERO;
			if (req.read && !wrong_role) begin
				case (req.address)
					usfi_pkg::OFS_BUS_CFG: nxt_rdata = cfg_ff;
					usfi_pkg::OFS_FLAGS: nxt_rdata = flags;
					usfi_pkg::OFS_ENABLE: nxt_rdata = en_ff;
					usfi_pkg::OFS_HOST_FRAME: nxt_rdata = frame_word;
					usfi_pkg::OFS_DEV_STATUS: nxt_rdata = frame_word;
					default: nxt_rdata = usfi_pkg::READ_ZERO;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt line
	// ------------------------------------------------------------
	// role bit 0 is no source, and bit 0 of the enable is reserved
	// sources split by role so a role change gates them at once
	always_comb begin
		// wakeup and session gates in both roles
		// id pin change gate in both roles
		// bit 21 meaning follows the role, one gate serves both
		shared_src = flags & en_ff & usfi_pkg::EN_WRITABLE_MASK &
			~usfi_pkg::HOST_ONLY_MASK & ~usfi_pkg::DEV_ONLY_MASK;
		// low flag gates, tx empty counted in host mode only
		host_src = flags & en_ff & usfi_pkg::HOST_ONLY_MASK & {32{HOST_MODE}};
		dev_src = flags & en_ff & usfi_pkg::DEV_ONLY_MASK & {32{!HOST_MODE}};
	end

	// the line is the or of every gated source
	always_comb begin
		// flags stay set, only the line is gated
		nxt_irq = |(shared_src | host_src | dev_src);
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	// sticky flags start clear so no stale fault follows reset
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			sof_ff <= 1'b0;
			mf_ff <= 1'b0;
		end else begin
			sof_ff <= nxt_sof;
			mf_ff <= nxt_mf;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			en_ff <= usfi_pkg::EN_RESET;
			cfg_ff <= usfi_pkg::CFG_RESET;
		end else begin
			en_ff <= nxt_en;
			cfg_ff <= nxt_cfg;
		end
	end

	// read data rests at zero until the first access
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rdata_ff <= usfi_pkg::READ_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// interrupt line stays quiet through reset
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign AVS_READDATA = rdata_ff;
	assign IRQ = irq_ff; // one cycle behind the flags it reflects

endmodule

// ===== rtl/usfi_pkg.sv
// usfi_pkg: shared constants and types of the global interrupt flag and enable logic
package usfi_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_BUS_CFG = 12'h008;
	localparam logic [11:0] OFS_FLAGS = 12'h014;
	localparam logic [11:0] OFS_ENABLE = 12'h018;
	localparam logic [11:0] OFS_HOST_FRAME = 12'h408;
	localparam logic [11:0] OFS_DEV_STATUS = 12'h808;

	// ------------------------------------------------------------
	// flag and enable bit positions
	// ------------------------------------------------------------
	localparam int BIT_ROLE = 0;
	localparam int BIT_MODE_FAULT = 1;
	localparam int BIT_OTG = 2;
	localparam int BIT_SOF = 3;
	localparam int BIT_RX_NONEMPTY = 4;
	localparam int BIT_NPTX_EMPTY = 5;
	localparam int BIT_UPPER_LO = 6;
	localparam int BIT_TX_THRESHOLD = 7;

	// ------------------------------------------------------------
	// role masks, writable masks and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] HOST_ONLY_MASK = 32'h0700_0020;
	localparam logic [31:0] DEV_ONLY_MASK = 32'h201C_FCC0;
	localparam logic [31:0] EN_WRITABLE_MASK = 32'hF73C_FCFE;
	localparam logic [31:0] EN_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_WRITABLE_MASK = 32'h0000_0080;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] FLAG_W1C_MASK = 32'h0000_000A;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// default widths
	// ------------------------------------------------------------
	localparam int FRAME_W_DEF = 11;
	localparam int RX_CNT_W_DEF = 5;
	localparam int OTG_W_DEF = 8;

	// register access classes
	typedef enum logic [1:0] {
		USFI_CLS_NONE = 2'b00,
		USFI_CLS_BOTH = 2'b01,
		USFI_CLS_HOST = 2'b11,
		USFI_CLS_DEV = 2'b10
	} usfi_cls_t;

	// bus handshake states, gray along idle -> ack -> idle
	typedef enum logic [1:0] {
		USFI_IDLE = 2'b00,
		USFI_ACK = 2'b01
	} usfi_bus_state_t;

	// one avalon request as seen by the slave
	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} usfi_avs_req_t;

	// fifo and frame events from the core
	typedef struct packed {
		logic nptx_half_empty;
		logic nptx_empty;
		logic rx_nonempty;
		logic sof_event;
	} usfi_core_evt_t;

endpackage

// ===== rtl/usfi_avs_handshake.sv
// usfi_avs_handshake: avalon waitrequest sequencing for one access at a time
`timescale 1ns/1ps
module usfi_avs_handshake (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic sample,
	output logic commit,
	output logic waitrequest
);

	usfi_pkg::usfi_bus_state_t state_ff;
	usfi_pkg::usfi_bus_state_t nxt_state;
	logic wait_ff;
	logic nxt_wait;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// one wait cycle: data is captured in idle, the access lands in ack
	always_comb begin
		nxt_state = state_ff;
		nxt_wait = 1'b1;
		sample = 1'b0;
		commit = 1'b0;
		case (state_ff)
			usfi_pkg::USFI_IDLE: begin
				if (req_valid) begin
					sample = 1'b1;
					nxt_state = usfi_pkg::USFI_ACK;
					nxt_wait = 1'b0;
				end
			end
			usfi_pkg::USFI_ACK: begin
				commit = req_valid; // master samples waitrequest low here
				nxt_state = usfi_pkg::USFI_IDLE;
			end
			default: begin
				nxt_state = usfi_pkg::USFI_IDLE;
			end
		endcase
	end

	// waitrequest rests high so no access slips through unobserved
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= usfi_pkg::USFI_IDLE;
			wait_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			wait_ff <= nxt_wait;
		end
	end

	assign waitrequest = wait_ff;

endmodule

// ===== verif/usfi_global_irq_props.sv
// checker: bus answer and flag readback relations of the global interrupt block
`timescale 1ns/1ps
module usfi_global_irq_props #(
	parameter int FRAME_W = 11,
	parameter int RX_CNT_W = 5,
	parameter int OTG_W = 8
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic [usfi_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic HOST_MODE,
	input wire logic NPTX_EMPTY,
	input wire logic [RX_CNT_W-1:0] RX_ENTRY_COUNT,
	input wire logic [OTG_W-1:0] OTG_FLAGS,
	input wire logic [FRAME_W-1:0] FRAME_NUMBER,
	input wire logic IRQ
);
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);
	logic flag_rd;
	logic stat_rd;
	logic hfrm_rd;
	// reads seen at the edge where the master takes the data
	assign flag_rd = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == usfi_pkg::OFS_FLAGS;
	assign stat_rd = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == usfi_pkg::OFS_DEV_STATUS;
	assign hfrm_rd = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == usfi_pkg::OFS_HOST_FRAME;
	// --------------------------------------------------------
	// assertions
	// --------------------------------------------------------
	// one wait state, then the answer stands for exactly one cycle
	sequence ack_once;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	bus_answer_a: assert property ($rose(AVS_READ || AVS_WRITE) |=> ack_once)
		else $error("bus answer not one cycle after request");
	quiet_reset_a: assert property ($fell(RESET) |-> AVS_WAITREQUEST && !IRQ && AVS_READDATA == 32'h0000_0000)
		else $error("outputs not at rest after reset");
	role_bit_a: assert property (flag_rd |-> AVS_READDATA[0] == $past(HOST_MODE))
		else $error("role bit wrong");
	rx_flag_a: assert property (flag_rd |-> AVS_READDATA[4] == ($past(RX_ENTRY_COUNT) != '0))
		else $error("rx non-empty flag wrong");
	otg_sum_a: assert property (flag_rd |-> AVS_READDATA[2] == |$past(OTG_FLAGS))
		else $error("otg summary flag wrong");
	nptx_host_a: assert property (flag_rd && $past(HOST_MODE) && $past(NPTX_EMPTY) |-> AVS_READDATA[5])
		else $error("tx empty flag missing when fifo empty");
	role_mask_a: assert property (flag_rd |-> (AVS_READDATA & ($past(HOST_MODE) ?
		usfi_pkg::DEV_ONLY_MASK : usfi_pkg::HOST_ONLY_MASK)) == 32'h0000_0000)
		else $error("flag of inactive role visible");
	frame_read_a: assert property (stat_rd && !$past(HOST_MODE) |->
		AVS_READDATA[FRAME_W-1:0] == $past(FRAME_NUMBER))
		else $error("frame number readback wrong");
	wrong_role_a: assert property (hfrm_rd && !$past(HOST_MODE) |-> AVS_READDATA == 32'h0000_0000)
		else $error("wrong-role read returned data");
endmodule

// ===== verif/usfi_usb_side_model.sv
// usb side model: fifo levels, frame start pulses and frame count of the core
`timescale 1ns/1ps
module usfi_usb_side_model #(
	parameter int FRAME_W = 11,
	parameter int RX_CNT_W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire usfi_pkg::usfi_core_evt_t cmd,
	input wire logic [RX_CNT_W-1:0] rx_cmd,
	output usfi_pkg::usfi_core_evt_t evt,
	output logic [RX_CNT_W-1:0] rx_count,
	output logic [FRAME_W-1:0] frame_number
);
	usfi_pkg::usfi_core_evt_t evt_ff;
	usfi_pkg::usfi_core_evt_t nxt_evt;
	logic req_ff;
	logic [FRAME_W-1:0] frame_ff;
	logic [FRAME_W-1:0] nxt_frame;
	// one frame-start pulse per request edge, so a held request cannot flood the flag
	always_comb begin
		nxt_evt = cmd;
		nxt_evt.sof_event = cmd.sof_event && !req_ff;
		nxt_frame = frame_ff + FRAME_W'(nxt_evt.sof_event);
	end
	// levels reach the block a cycle after the command
	always_ff @(posedge clk) begin
		if (rst) begin
			evt_ff <= '0;
			req_ff <= 1'b0;
			frame_ff <= '0;
			rx_count <= '0;
		end else begin
			evt_ff <= nxt_evt;
			req_ff <= cmd.sof_event;
			frame_ff <= nxt_frame;
			rx_count <= rx_cmd;
		end
	end
	assign evt = evt_ff;
	assign frame_number = frame_ff;
endmodule

// ===== verif/tb_usfi_global_irq.sv
// testbench: flags, enables and interrupt line of the global interrupt block
`timescale 1ns/1ps
module tb_usfi_global_irq;
	// ctl holds host, threshold, half empty, empty
	typedef struct packed {
		logic [3:0] ctl;
		logic [31:0] en;
		logic [4:0] rx;
		logic [7:0] otg;
		logic [31:0] up;
		logic [31:0] flags;
		logic irq;
	} usfi_row_t;
	logic CORE_CLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, HOST_MODE, IRQ;
	logic [11:0] AVS_ADDRESS;
	logic [3:0] AVS_BYTEENABLE;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, UPPER_FLAGS, q;
	logic [4:0] rx_cmd, RX_ENTRY_COUNT;
	logic [7:0] OTG_FLAGS;
	logic [10:0] FRAME_NUMBER;
	usfi_pkg::usfi_core_evt_t cmd, evt;
	int n_errors = 0;
	int check_count = 0;
	usfi_row_t rows [17] = '{
		'{4'hA, 32'h0000_0020, 5'h00, 8'h00, 32'h0000_0000, 32'h0000_0021, 1'b1},
		'{4'hE, 32'h0000_0020, 5'h00, 8'h00, 32'h0000_0000, 32'h0000_0001, 1'b0},
		'{4'hF, 32'h0000_0020, 5'h00, 8'h00, 32'h0000_0000, 32'h0000_0021, 1'b1},
		'{4'h8, 32'h0000_0000, 5'h03, 8'h00, 32'h0000_0000, 32'h0000_0011, 1'b0},
		'{4'h8, 32'h0000_0010, 5'h01, 8'h00, 32'h0000_0000, 32'h0000_0011, 1'b1},
		'{4'h8, 32'h0000_0004, 5'h00, 8'h80, 32'h0000_0000, 32'h0000_0005, 1'b1},
		'{4'h8, 32'h0700_0000, 5'h00, 8'h00, 32'h0400_0000, 32'h0400_0001, 1'b1},
		'{4'h8, 32'hD000_0000, 5'h00, 8'h00, 32'h1000_0000, 32'h1000_0001, 1'b1},
		'{4'h8, 32'h0020_0000, 5'h00, 8'h00, 32'h0020_0000, 32'h0020_0001, 1'b1},
		'{4'h8, 32'h0008_0000, 5'h00, 8'h00, 32'h0008_0000, 32'h0000_0001, 1'b0},
		'{4'h0, 32'h2000_0000, 5'h00, 8'h00, 32'h2000_0000, 32'h2000_0000, 1'b1},
		'{4'h0, 32'h001C_0000, 5'h00, 8'h00, 32'h0004_0000, 32'h0004_0000, 1'b1},
		'{4'h0, 32'h0020_0000, 5'h00, 8'h00, 32'h0020_0000, 32'h0020_0000, 1'b1},
		'{4'h0, 32'h0000_E000, 5'h00, 8'h00, 32'h0000_2000, 32'h0000_2000, 1'b1},
		'{4'h0, 32'h0000_1CC0, 5'h00, 8'h00, 32'h0000_0040, 32'h0000_0040, 1'b1},
		'{4'h3, 32'h0100_0020, 5'h00, 8'h00, 32'h0100_0000, 32'h0000_0000, 1'b0},
		'{4'h0, 32'h0000_0000, 5'h00, 8'h00, 32'h0000_0800, 32'h0000_0800, 1'b0}};

	usfi_global_irq dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HOST_MODE(HOST_MODE),
		.NPTX_HALF_EMPTY(evt.nptx_half_empty), .NPTX_EMPTY(evt.nptx_empty), .RX_ENTRY_COUNT(RX_ENTRY_COUNT),
		.SOF_EVENT(evt.sof_event), .OTG_FLAGS(OTG_FLAGS), .UPPER_FLAGS(UPPER_FLAGS[31:6]),
		.FRAME_NUMBER(FRAME_NUMBER), .IRQ(IRQ));
	usfi_usb_side_model model (.clk(CORE_CLK), .rst(RESET), .cmd(cmd), .rx_cmd(rx_cmd), .evt(evt),
		.rx_count(RX_ENTRY_COUNT), .frame_number(FRAME_NUMBER));

	initial begin
		CORE_CLK = 1'b0;
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end

	// --------------------------------------------------------
	// checking and bus tasks
	// --------------------------------------------------------
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until waitrequest is seen low; bounded so a dead slave ends the run
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			final_report();
		end
		@(posedge CORE_CLK);
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask
	// irq lags its cause by an edge; sampled mid-cycle once settled
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk("irq", {31'h0, e}, {31'h0, IRQ});
		@(posedge CORE_CLK);
	endtask

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial begin
		{RESET, AVS_READ, AVS_WRITE, HOST_MODE, AVS_ADDRESS, AVS_WRITEDATA} <= {1'b1, 47'h0};
		{AVS_BYTEENABLE, rx_cmd, OTG_FLAGS, UPPER_FLAGS, cmd} <= {4'hF, 49'h0};
		repeat (5) @(posedge CORE_CLK);
		RESET <= 1'b0;
		@(negedge CORE_CLK);
		chk("wait at rest", 32'h0000_0001, {31'h0, AVS_WAITREQUEST});
		chk_irq(1'b0);
		rd_chk("enable reset", usfi_pkg::OFS_ENABLE, usfi_pkg::EN_RESET);
		foreach (rows[i]) begin
			HOST_MODE <= rows[i].ctl[3];
			cmd <= {rows[i].ctl[1:0], 2'b00};
			rx_cmd <= rows[i].rx;
			OTG_FLAGS <= rows[i].otg;
			UPPER_FLAGS <= rows[i].up;
			@(posedge CORE_CLK);
			// reserved enable bits stay zero in every row
			bus(1'b1, usfi_pkg::OFS_BUS_CFG, {24'h00_0000, rows[i].ctl[2], 7'h00});
			bus(1'b1, usfi_pkg::OFS_ENABLE, rows[i].en);
			rd_chk("flags", usfi_pkg::OFS_FLAGS, rows[i].flags);
			chk_irq(rows[i].irq);
		end
		// frame start in device mode, then write-one clear
		UPPER_FLAGS <= 32'h0000_0000;
		bus(1'b1, usfi_pkg::OFS_ENABLE, 32'h0000_000A);
		cmd.sof_event <= 1'b1;
		@(posedge CORE_CLK);
		cmd.sof_event <= 1'b0;
		@(posedge CORE_CLK);
		rd_chk("sof flag", usfi_pkg::OFS_FLAGS, 32'h0000_0008);
		rd_chk("frame", usfi_pkg::OFS_DEV_STATUS, 32'h0000_0001);
		chk_irq(1'b1);
		bus(1'b1, usfi_pkg::OFS_FLAGS, 32'h0000_0000);
		rd_chk("sof kept", usfi_pkg::OFS_FLAGS, 32'h0000_0008);
		bus(1'b1, usfi_pkg::OFS_FLAGS, 32'h0000_0008);
		rd_chk("sof cleared", usfi_pkg::OFS_FLAGS, 32'h0000_0000);
		chk_irq(1'b0);
		// wrong-role accesses in both roles
		rd_chk("host reg", usfi_pkg::OFS_HOST_FRAME, 32'h0000_0000);
		rd_chk("fault", usfi_pkg::OFS_FLAGS, 32'h0000_0002);
		chk_irq(1'b1);
		bus(1'b1, usfi_pkg::OFS_FLAGS, 32'h0000_0002);
		HOST_MODE <= 1'b1;
		@(posedge CORE_CLK);
		bus(1'b1, usfi_pkg::OFS_DEV_STATUS, 32'hFFFF_FFFF);
		rd_chk("fault host", usfi_pkg::OFS_FLAGS, 32'h0000_0003);
		bus(1'b1, usfi_pkg::OFS_ENABLE, 32'h0008_0002);
		rd_chk("enable role", usfi_pkg::OFS_ENABLE, 32'h0000_0002);
		// host frame start, then an enable write on one byte lane only
		cmd.sof_event <= 1'b1;
		@(posedge CORE_CLK);
		cmd.sof_event <= 1'b0;
		@(posedge CORE_CLK);
		rd_chk("host sof", usfi_pkg::OFS_FLAGS, 32'h0000_000B);
		rd_chk("host frame", usfi_pkg::OFS_HOST_FRAME, 32'h0000_0002);
		AVS_BYTEENABLE <= 4'h1;
		bus(1'b1, usfi_pkg::OFS_ENABLE, 32'hFFFF_FF3C);
		AVS_BYTEENABLE <= 4'hF;
		rd_chk("enable lane", usfi_pkg::OFS_ENABLE, 32'h0000_003C);
		rd_chk("unmapped", 12'h100, 32'h0000_0000);
		// second reset in mid-run
		RESET <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		@(posedge CORE_CLK);
		rd_chk("enable rst2", usfi_pkg::OFS_ENABLE, 32'h0000_0000);
		rd_chk("flags rst2", usfi_pkg::OFS_FLAGS, 32'h0000_0001);
		final_report();
	end
endmodule

bind usfi_global_irq usfi_global_irq_props #(.FRAME_W(FRAME_W), .RX_CNT_W(RX_CNT_W), .OTG_W(OTG_W)) props (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HOST_MODE(HOST_MODE),
	.NPTX_EMPTY(NPTX_EMPTY), .RX_ENTRY_COUNT(RX_ENTRY_COUNT), .OTG_FLAGS(OTG_FLAGS),
	.FRAME_NUMBER(FRAME_NUMBER), .IRQ(IRQ));
